// ---- shared/lpt_pkg.sv ----
// line progress tracking: constants, register map and carrier types
// assumes a single clock domain and an axi4-lite master on the host side
package lpt_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CHAR_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int COUNT_W = 16;
   localparam int MODE_W = 3;
   localparam int CHK_W = 16;

   // register byte addresses
   localparam logic [ADDR_W-1:0] OFF_PROGRESS = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_TX_MODE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_BYTE_COUNT = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_CHECK_TYPE = 8'h0c;

   // progress register fields, plus the byte count register marker bit
   localparam int BIT_FIRST_NEXT = 0;
   localparam int BIT_SECOND_NEXT = 1;
   localparam int BIT_RESYNC = 7;
   localparam int BIT_APPEND = 10;
   localparam int NMODE_LSB = 13;
   localparam int BIT_COUNT_MARK = 16;

   localparam logic [MODE_W-1:0] RST_MODE = 3'h0;
   localparam logic [COUNT_W-1:0] RST_COUNT = 16'h0000;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;

   // block check type encodings
   localparam logic [1:0] CHK_LRC8 = 2'h0;
   localparam logic [1:0] CHK_CRC16 = 2'h1;
   localparam logic [1:0] CHK_CCITT = 2'h2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic marker;
      logic [CHAR_W-1:0] data;
   } lpt_rxchar_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [3:0] strb;
   } lpt_wreq_t;

   typedef enum logic [1:0] {TX_DATA, TX_FIRST, TX_SECOND} lpt_txst_t;
endpackage

// ---- rtl/lpt_fifo.sv ----
// small flop-based fifo with valid/ready on both sides
// assumes both sides share the block clock
`timescale 1ns/1ps
module lpt_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [PW:0] cnt_q, cnt_d;
   logic push, pop;

   assign in_ready = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      wp_d = push ? ((wp_q == PW'(DEPTH-1)) ? '0 : wp_q + 1'b1) : wp_q;
      rp_d = pop ? ((rp_q == PW'(DEPTH-1)) ? '0 : rp_q + 1'b1) : rp_q;
      cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end
endmodule

// ---- rtl/lpt_axil.sv ----
// axi4-lite slave front end: one write and one read in flight
// assumes the parent decodes addresses combinationally
`timescale 1ns/1ps
module lpt_axil
   import lpt_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [lpt_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [lpt_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [lpt_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [lpt_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_en,
   output lpt_pkg::lpt_wreq_t wr_req,
   input wire logic wr_ok,
   input wire logic [lpt_pkg::DATA_W-1:0] rd_data,
   input wire logic rd_ok
);
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [ADDR_W-1:0] aw_q, aw_d;
   logic [DATA_W-1:0] w_q, w_d;
   logic [3:0] s_q, s_d;
   logic bvalid_d, rvalid_d;
   logic [1:0] bresp_d, rresp_d;
   logic [DATA_W-1:0] rdata_d;

   assign awready = !aw_have_q && !bvalid;
   assign wready = !w_have_q && !bvalid;
   assign arready = !rvalid;
   assign wr_en = aw_have_q && w_have_q;
   assign wr_req = '{addr: aw_q, data: w_q, strb: s_q};

   always_comb begin
      aw_have_d = aw_have_q;
      aw_d = aw_q;
      w_have_d = w_have_q;
      w_d = w_q;
      s_d = s_q;
      bvalid_d = bvalid;
      bresp_d = bresp;
      rvalid_d = rvalid;
      rresp_d = rresp;
      rdata_d = rdata;
      if (awvalid && awready) begin
         aw_have_d = 1'b1;
         aw_d = awaddr;
      end
      if (wvalid && wready) begin
         w_have_d = 1'b1;
         w_d = wdata;
         s_d = wstrb;
      end
      if (wr_en) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
         bvalid_d = 1'b0;
      end
      if (arvalid && arready) begin
         rvalid_d = 1'b1;
         rdata_d = rd_ok ? rd_data : '0;
         rresp_d = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= '0;
         w_q <= '0;
         s_q <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= RESP_OKAY;
         rdata <= '0;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         aw_q <= aw_d;
         w_q <= w_d;
         s_q <= s_d;
         bvalid <= bvalid_d;
         bresp <= bresp_d;
         rvalid <= rvalid_d;
         rresp <= rresp_d;
         rdata <= rdata_d;
      end
   end
endmodule

// ---- rtl/lpt_top.sv ----
// per-line progress tracking: resync hold on receive, check append and mode swap on transmit
// assumes receive/transmit streams and check accumulator come from logic on the same clock
`timescale 1ns/1ps
module lpt_top
   import lpt_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [lpt_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [lpt_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [lpt_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [lpt_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic resync_start,
   input wire logic rx_valid,
   output logic rx_ready,
   input wire lpt_pkg::lpt_rxchar_t rx_char,
   output logic host_valid,
   input wire logic host_ready,
   output logic [lpt_pkg::CHAR_W-1:0] host_data,
   input wire logic src_valid,
   output logic src_ready,
   input wire logic [lpt_pkg::CHAR_W-1:0] src_data,
   input wire logic [lpt_pkg::CHK_W-1:0] check_value,
   output logic line_valid,
   input wire logic line_ready,
   output logic [lpt_pkg::CHAR_W-1:0] line_data,
   output logic [lpt_pkg::MODE_W-1:0] tx_mode
);
   import lpt_pkg::*;

   logic wr_en, wr_ok, rd_ok;
   lpt_wreq_t wr_req;
   logic [DATA_W-1:0] rd_data;
   logic aw_ready_i, w_ready_i, ar_ready_i;

   // host-visible state
   logic append_q, append_d;
   logic [MODE_W-1:0] nmode_q, nmode_d;
   logic [MODE_W-1:0] mode_q, mode_d;
   logic [COUNT_W-1:0] count_q, count_d;
   logic mark_q, mark_d;
   logic [1:0] ctype_q, ctype_d;

   // receive side
   logic resync_q, resync_d, seen_q, seen_d;
   logic hv_q, hv_d;
   logic [CHAR_W-1:0] hd_q, hd_d;
   logic f_valid, f_pop;
   lpt_rxchar_t f_char;
   logic hold, slot_free;

   // transmit side
   lpt_txst_t st_q, st_d;
   logic first_next_q, first_next_d, second_next_q, second_next_d;
   logic lv_q, lv_d;
   logic [CHAR_W-1:0] ld_q, ld_d;
   logic line_free, take, hits_zero;

   assign awready = aw_ready_i;
   assign wready = w_ready_i;
   assign arready = ar_ready_i;

   lpt_axil lpt_axil_i (
      .clock(clock),
      .nrst(nrst),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(aw_ready_i),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(w_ready_i),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(ar_ready_i),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wr_en(wr_en),
      .wr_req(wr_req),
      .wr_ok(wr_ok),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );

   lpt_fifo #(.WIDTH($bits(lpt_rxchar_t)), .DEPTH(FIFO_DEPTH)) lpt_fifo_i (
      .clock(clock),
      .nrst(nrst),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data(rx_char),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_char)
   );

   // register decode
   always_comb begin
      rd_data = '0;
      rd_ok = 1'b1;
      case (araddr)
         OFF_PROGRESS: begin
            rd_data[BIT_FIRST_NEXT] = first_next_q;
            rd_data[BIT_SECOND_NEXT] = second_next_q;
            rd_data[BIT_RESYNC] = resync_q;
            rd_data[BIT_APPEND] = append_q;
            rd_data[NMODE_LSB +: MODE_W] = nmode_q;
         end
         OFF_TX_MODE: rd_data[MODE_W-1:0] = mode_q;
         OFF_BYTE_COUNT: begin
            rd_data[COUNT_W-1:0] = count_q;
            rd_data[BIT_COUNT_MARK] = mark_q;
         end
         OFF_CHECK_TYPE: rd_data[1:0] = ctype_q;
         default: rd_ok = 1'b0;
      endcase
      case (wr_req.addr)
         OFF_PROGRESS, OFF_TX_MODE, OFF_BYTE_COUNT, OFF_CHECK_TYPE: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // receive path: hold and drop stale characters until the marker leaves the fifo
   assign hold = resync_q && !seen_q;
   assign slot_free = !hv_q || host_ready;
   assign f_pop = f_valid && (hold || slot_free);

   always_comb begin
      resync_d = resync_q;
      seen_d = seen_q;
      hv_d = slot_free ? 1'b0 : hv_q;
      hd_d = hd_q;
      if (f_pop) begin
         if (hold) begin
            if (f_char.marker) begin
               seen_d = 1'b1;
            end
         end else begin
            hv_d = 1'b1;
            hd_d = f_char.data;
         end
      end
      if (resync_q && seen_q && !f_valid) begin
         resync_d = 1'b0;
      end
      if (resync_start) begin
         resync_d = 1'b1;
         seen_d = 1'b0;
      end
   end

   // transmit path
   assign line_free = !lv_q || line_ready;
   assign src_ready = (st_q == TX_DATA) && line_free;
   assign take = src_valid && src_ready;
   assign hits_zero = take && mark_q && (count_q == COUNT_ONE);

   always_comb begin
      st_d = st_q;
      first_next_d = first_next_q;
      second_next_d = second_next_q;
      lv_d = line_free ? 1'b0 : lv_q;
      ld_d = ld_q;
      mode_d = mode_q;
      count_d = count_q;
      mark_d = mark_q;
      append_d = append_q;
      nmode_d = nmode_q;
      ctype_d = ctype_q;
      case (st_q)
         TX_DATA: begin
            if (take) begin
               lv_d = 1'b1;
               ld_d = src_data;
               if (count_q != RST_COUNT) begin
                  count_d = count_q - COUNT_ONE;
               end
               if (hits_zero) begin
                  mark_d = 1'b0;
                  mode_d = nmode_q;
                  if (append_q) begin
                     first_next_d = 1'b1;
                     st_d = TX_FIRST;
                  end
               end
            end
         end
         TX_FIRST: begin
            if (line_free) begin
               lv_d = 1'b1;
               ld_d = check_value[CHAR_W-1:0];
               first_next_d = 1'b0;
               if (ctype_q == CHK_CRC16 || ctype_q == CHK_CCITT) begin
                  second_next_d = 1'b1;
                  st_d = TX_SECOND;
               end else begin
                  st_d = TX_DATA;
               end
            end
         end
         TX_SECOND: begin
            if (line_free) begin
               lv_d = 1'b1;
               ld_d = check_value[CHK_W-1:CHAR_W];
               second_next_d = 1'b0;
               st_d = TX_DATA;
            end
         end
         default: st_d = TX_DATA;
      endcase
      if (wr_en && wr_ok) begin
         case (wr_req.addr)
            OFF_PROGRESS: begin
               // only the host-owned fields take a write; the rest are sequencer state
               if (wr_req.strb[1]) begin
                  append_d = wr_req.data[BIT_APPEND];
                  nmode_d = wr_req.data[NMODE_LSB +: MODE_W];
               end
            end
            OFF_TX_MODE: begin
               if (wr_req.strb[0] && !hits_zero) begin
                  mode_d = wr_req.data[MODE_W-1:0];
               end
            end
            OFF_BYTE_COUNT: begin
               if (wr_req.strb[0]) begin
                  count_d[CHAR_W-1:0] = wr_req.data[CHAR_W-1:0];
               end
               if (wr_req.strb[1]) begin
                  count_d[COUNT_W-1:CHAR_W] = wr_req.data[COUNT_W-1:CHAR_W];
               end
               if (wr_req.strb[2]) begin
                  mark_d = wr_req.data[BIT_COUNT_MARK];
               end
            end
            OFF_CHECK_TYPE: begin
               if (wr_req.strb[0]) begin
                  ctype_d = wr_req.data[1:0];
               end
            end
            default: ctype_d = ctype_q;
         endcase
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         resync_q <= 1'b0;
         seen_q <= 1'b0;
         hv_q <= 1'b0;
         hd_q <= '0;
         st_q <= TX_DATA;
         first_next_q <= 1'b0;
         second_next_q <= 1'b0;
         lv_q <= 1'b0;
         ld_q <= '0;
         mode_q <= RST_MODE;
         count_q <= RST_COUNT;
         mark_q <= 1'b0;
         append_q <= 1'b0;
         nmode_q <= RST_MODE;
         ctype_q <= CHK_LRC8;
      end else begin
         resync_q <= resync_d;
         seen_q <= seen_d;
         hv_q <= hv_d;
         hd_q <= hd_d;
         st_q <= st_d;
         first_next_q <= first_next_d;
         second_next_q <= second_next_d;
         lv_q <= lv_d;
         ld_q <= ld_d;
         mode_q <= mode_d;
         count_q <= count_d;
         mark_q <= mark_d;
         append_q <= append_d;
         nmode_q <= nmode_d;
         ctype_q <= ctype_d;
      end
   end

   assign host_valid = hv_q;
   assign host_data = hd_q;
   assign line_valid = lv_q;
   assign line_data = ld_q;
   assign tx_mode = mode_q;
endmodule

// ---- dv/lpt_monitor.sv ----
// checker on lpt_top ports: handshake holds, answer timing, mode-change causes
// assumes it is bound to lpt_top and shares its clock and reset
`timescale 1ns/1ps
module lpt_monitor
   import lpt_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [lpt_pkg::DATA_W-1:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic host_valid,
   input wire logic host_ready,
   input wire logic [lpt_pkg::CHAR_W-1:0] host_data,
   input wire logic src_valid,
   input wire logic src_ready,
   input wire logic [lpt_pkg::CHAR_W-1:0] src_data,
   input wire logic line_valid,
   input wire logic line_ready,
   input wire logic [lpt_pkg::CHAR_W-1:0] line_data,
   input wire logic [lpt_pkg::MODE_W-1:0] tx_mode
);
   default clocking mon_cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   property p_wr_answer; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_rd_answer; arvalid && arready |=> rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_ar_busy; rvalid |-> !arready; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
   property p_host_hold; host_valid && !host_ready |=> host_valid && $stable(host_data);
   endproperty
   a_host_hold: assert property (p_host_hold) else $error("host char dropped");
   property p_src_line; src_valid && src_ready |=> line_valid && line_data == $past(src_data);
   endproperty
   a_src_line: assert property (p_src_line) else $error("char not forwarded");
   property p_line_hold; line_valid && !line_ready |=> line_valid && $stable(line_data);
   endproperty
   a_line_hold: assert property (p_line_hold) else $error("line char dropped");
   property p_mode_cause;
      !$stable(tx_mode) |-> $past(src_valid && src_ready) || $rose(bvalid);
   endproperty
   a_mode_cause: assert property (p_mode_cause) else $error("mode changed uncaused");
endmodule
bind lpt_top lpt_monitor lpt_monitor_i (.*);

// ---- dv/lpt_line_sink.sv ----
// line-side partner: takes transmit characters, stalling every other cycle on request
// assumes the block clock and active-low reset
`timescale 1ns/1ps
module lpt_line_sink
   import lpt_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic stall,
   input wire logic line_valid,
   output logic line_ready,
   input wire logic [lpt_pkg::CHAR_W-1:0] line_data
);
   logic [CHAR_W-1:0] got [$];
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         line_ready <= 1'b0;
      end else begin
         line_ready <= stall ? !line_ready : 1'b1;
         if (line_valid && line_ready) begin
            got.push_back(line_data);
         end
      end
   end
endmodule

// ---- dv/lpt_top_tb_top.sv ----
// testbench for lpt_top: register map, resync hold, check append and mode swap
// assumes lpt_line_sink on the line side and lpt_monitor bound to the design
`timescale 1ns/1ps
module lpt_top_tb_top;
   import lpt_pkg::*;
   typedef struct packed {
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] w;
      logic [DATA_W-1:0] e;
      logic [1:0] r;
   } lpt_row_t;
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin n_mismatch++; \
$display("BAD t=%0t got=%h exp=%h", $time, (g), (x)); end end
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [DATA_W-1:0] wdata = '0, rdata, rd;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, rx_ready, host_valid;
   logic src_ready, line_valid, line_ready;
   logic [1:0] bresp, rresp, resp;
   logic resync_start = 0, rx_valid = 0, host_ready = 0, src_valid = 0, stall = 0, hdrain = 0;
   lpt_rxchar_t rx_char = '0;
   logic [CHAR_W-1:0] host_data, line_data, src_data = '0;
   logic [CHK_W-1:0] check_value = '0;
   logic [MODE_W-1:0] tx_mode;
   logic [CHAR_W-1:0] hq [$];
   logic [CHAR_W-1:0] exp_q [$];
   int n_mismatch = 0, checked = 0, n, k, base;
   lpt_rxchar_t rxs [5] = '{9'h001, 9'h002, 9'h17e, 9'h055, 9'h066};
   lpt_row_t rows [5] = '{
      '{OFF_PROGRESS, 32'hffff_ffff, 32'h0000_e400, RESP_OKAY},
      '{OFF_TX_MODE, 32'hffff_ffff, 32'h0000_0007, RESP_OKAY},
      '{OFF_BYTE_COUNT, 32'h0001_1234, 32'h0001_1234, RESP_OKAY},
      '{OFF_CHECK_TYPE, 32'h0000_0002, 32'h0000_0002, RESP_OKAY},
      '{8'h10, 32'hffff_ffff, 32'h0000_0000, RESP_SLVERR}};

   lpt_top lpt_top_i (.*);
   lpt_line_sink lpt_line_sink_i (.*);

   always #12.5 clock = ~clock;
   always @(posedge clock) begin
      if (host_valid && host_ready) hq.push_back(host_data);
      if (hdrain) host_ready <= !host_ready;
   end

   task automatic give_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic aw_done;
      logic w_done;
      @(posedge clock);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_done = 1'b0;
      w_done = 1'b0;
      do begin
         @(posedge clock);
         if (!aw_done && awready) begin
            awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (!w_done && wready) begin
            wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end while (!(aw_done && w_done));
      do @(posedge clock); while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [ADDR_W-1:0] a);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clock); while (!rvalid);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   task automatic push(input lpt_rxchar_t c);
      rx_char <= c;
      rx_valid <= 1'b1;
      do @(posedge clock); while (!rx_ready);
   endtask

   task automatic send(input logic [CHAR_W-1:0] c);
      src_data <= c;
      src_valid <= 1'b1;
      do @(posedge clock); while (!src_ready);
   endtask

   initial begin
      #1000000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      `CHK(tx_mode, RST_MODE)
      axi_rd(OFF_PROGRESS);
      `CHK(rd, 32'h0)
      foreach (rows[i]) begin
         axi_wr(rows[i].a, rows[i].w);
         `CHK(resp, rows[i].r)
         axi_rd(rows[i].a);
         `CHK({resp, rd}, {rows[i].r, rows[i].e})
      end
      // resync: characters before the marker, and the marker itself, never reach the host
      host_ready <= 1'b1;
      resync_start <= 1'b1;
      @(posedge clock);
      resync_start <= 1'b0;
      axi_rd(OFF_PROGRESS);
      `CHK(rd[BIT_RESYNC], 1'b1)
      foreach (rxs[i]) push(rxs[i]);
      rx_valid <= 1'b0;
      n = 0;
      while (hq.size() < 2 && n++ < 200) @(posedge clock);
      `CHK(hq[0], 8'h55)
      `CHK(hq[1], 8'h66)
      axi_rd(OFF_PROGRESS);
      `CHK(rd[BIT_RESYNC], 1'b0)
      // fill the receive path until refused, then drain with the host stalling
      host_ready <= 1'b0;
      k = 0;
      rx_char <= 9'h080;
      rx_valid <= 1'b1;
      do begin
         @(posedge clock);
         if (rx_ready) k++;
         rx_char <= lpt_rxchar_t'(9'h080 + 9'(k));
      end while (rx_ready && k < 8);
      rx_valid <= 1'b0;
      `CHK(k >= FIFO_DEPTH, 1'b1)
      hdrain <= 1'b1;
      n = 0;
      while (hq.size() < 2 + k && n++ < 400) @(posedge clock);
      hdrain <= 1'b0;
      for (int i = 0; i < k; i++) `CHK(hq[2 + i], CHAR_W'(8'h80 + i))
      `CHK(hq.size(), 2 + k)
      // transmit: every check type, then append off; line side stalls throughout
      stall <= 1'b1;
      for (int t = 0; t < 4; t++) begin
         check_value <= {8'hc0 + 8'(t), 8'ha0 + 8'(t)};
         axi_wr(OFF_CHECK_TYPE, DATA_W'(t % 3));
         axi_wr(OFF_PROGRESS, DATA_W'(((t + 1) << NMODE_LSB) | (t < 3 ? 1 << BIT_APPEND : 0)));
         axi_wr(OFF_BYTE_COUNT, 32'h0001_0002);
         base = lpt_line_sink_i.got.size();
         exp_q = '{8'h11 + 8'(t), 8'h22 + 8'(t)};
         if (t < 3) exp_q.push_back(8'ha0 + 8'(t));
         if (t == 1 || t == 2) exp_q.push_back(8'hc0 + 8'(t));
         exp_q.push_back(8'h99);
         send(exp_q[0]);
         send(exp_q[1]);
         send(8'h99);
         src_valid <= 1'b0;
         n = 0;
         while (lpt_line_sink_i.got.size() < base + exp_q.size() && n++ < 400) @(posedge clock);
         foreach (exp_q[i]) `CHK(lpt_line_sink_i.got[base + i], exp_q[i])
         `CHK(lpt_line_sink_i.got.size(), base + exp_q.size())
         `CHK(tx_mode, MODE_W'(t + 1))
      end
      // second reset in mid-run
      nrst <= 1'b0;
      @(posedge clock);
      `CHK({line_valid, host_valid, tx_mode}, 5'h0)
      nrst <= 1'b1;
      axi_rd(OFF_PROGRESS);
      `CHK(rd, 32'h0)
      give_verdict();
   end
endmodule
